// ### hdl/ebr_pkg.sv
// Function
// R1: Programmer pulses the device reset pin first
// R2: Wait 20 us after pin reset
// R3: Write 0x04 to device control; core halts
// R4: Write 0x00 to memory control selects read
// R5: Load high and low address bytes
// R6: Data read returns byte, address plus one
// R7: Error flag reported; programmer may abort
// R8: Repeat data reads or reload address
// R9: Leave read mode: write 0x40, then 0x00
// R10: Device control 0x02 then 0x00 resets device
// R11: Low nibble security zero blocks all reads
// R12: High nibble security zero blocks all writes
// R13: Status shows lock flags for address
// R14: Nothing ever restores lost access
// R15: Set write lock only after image done
// R16: Locked reads hide data, raise error
package ebr_pkg;
  localparam int CLK_MHZ = 25;
  localparam int RESET_WAIT_US = 20;
  localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int LK_HALF_CYC = 8;
  localparam int MEM_AW = 12;
  localparam int MEM_DEPTH = 4096;
  localparam logic [15:0] SEC_ADDR = 16'h0FFF;
  localparam logic [7:0] ERASED = 8'hFF;
  // Link register selects
  localparam logic [2:0] R_DEV_CTRL = 3'h0;
  localparam logic [2:0] R_MEM_CTRL = 3'h1;
  localparam logic [2:0] R_ADDRH = 3'h2;
  localparam logic [2:0] R_ADDRL = 3'h3;
  localparam logic [2:0] R_DATA = 3'h4;
  localparam logic [2:0] R_STAT = 3'h5;
  localparam logic [7:0] DEV_CTRL_HALT = 8'h04;
  localparam logic [7:0] DEV_CTRL_RST1 = 8'h02;
  localparam logic [7:0] DEV_CTRL_RST2 = 8'h00;
  localparam logic [7:0] MEM_CTRL_READ = 8'h00;
  localparam logic [7:0] MEM_CTRL_EXIT = 8'h40;
  localparam int HALT_BIT = 2;
  localparam int ST_ERR = 0;
  localparam int ST_RDLK = 1;
  localparam int ST_WRLK = 2;
  // Frame slots: start, op, 3 select bits, 8 data bits, stop
  localparam logic [3:0] SLOT_SEL_END = 4'h4;
  localparam logic [3:0] SLOT_DAT = 4'h5;
  localparam logic [3:0] SLOT_LAST = 4'hC;
  localparam logic [3:0] SLOT_STOP = 4'hD;
  localparam logic OP_WRITE = 1'b1;
  // Controller register offsets
  localparam int HREG_AW = 4;
  localparam logic [3:0] H_CMD = 4'h0;
  localparam logic [3:0] H_ADDRH = 4'h1;
  localparam logic [3:0] H_ADDRL = 4'h2;
  localparam logic [3:0] H_WDATA = 4'h3;
  localparam logic [3:0] H_RDATA = 4'h4;
  localparam logic [3:0] H_STATUS = 4'h5;
  localparam logic [3:0] H_IRQ_STAT = 4'h6;
  localparam logic [3:0] H_IRQ_MASK = 4'h7;
  localparam logic [3:0] H_IMAGE = 4'h8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  typedef enum logic [2:0] {
    EBR_OP_NONE = 3'b000,
    EBR_OP_OPEN = 3'b001,
    EBR_OP_ADDR = 3'b010,
    EBR_OP_READ = 3'b011,
    EBR_OP_WRITE = 3'b100,
    EBR_OP_CLOSE = 3'b101
  } ebr_op_t;
endpackage

// ### hdl/ebr_link_if.sv
`timescale 1ns/10ps
interface ebr_link_if;
  logic lk;
  logic rst_pin_n;
  logic host_o;
  logic host_oe_n;
  logic dev_o;
  logic dev_oe_n;
  logic dat;
  // Pulled high when nobody drives
  assign dat = !host_oe_n ? host_o : (!dev_oe_n ? dev_o : 1'b1);
  modport host (output lk, output rst_pin_n, output host_o, output host_oe_n, input dat);
  modport dev (input lk, input rst_pin_n, output dev_o, output dev_oe_n, input dat);
endinterface

// ### hdl/ebr_dev.sv
`timescale 1ns/10ps
module ebr_dev (
  // System
  input wire logic clk,
  input wire logic arst_n,
  // Debug link
  ebr_link_if.dev link,
  // Core side
  output logic core_halt,
  output logic dev_reset_pulse,
  output logic read_mode
);
  import ebr_pkg::*;
  typedef enum logic [1:0] {
    EBR_M_IDLE = 2'b00,
    EBR_M_READ = 2'b01,
    EBR_M_EXIT = 2'b10
  } ebr_mode_t;

  logic [7:0] mem [0:MEM_DEPTH-1];
  logic lk_s1, lk_s2, lk_s3, dat_s1, dat_s2, rst_s1, rst_s2;
  logic in_frame, cur_rd, err;
  logic [3:0] slot;
  logic [11:0] sh;
  logic [2:0] cur_reg;
  logic [7:0] tx, device_control_reg, memory_control_reg, addr_h, addr_l;
  ebr_mode_t mode, next_mode;

  // Blank one-time memory reads as all ones
  initial begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      mem[i] = ERASED;
    end
  end

  wire rise = lk_s2 & ~lk_s3;
  wire fall = ~lk_s2 & lk_s3;
  wire [11:0] next_sh = {sh[10:0], dat_s2};
  wire [15:0] addr_pair = {addr_h, addr_l};
  wire [MEM_AW-1:0] mem_idx = addr_pair[MEM_AW-1:0];
  wire in_range = addr_pair < 16'(MEM_DEPTH);
  wire [7:0] sec = mem[SEC_ADDR[MEM_AW-1:0]];
  wire rd_lock = ~&sec[3:0]; // [R11]
  wire wr_lock = ~&sec[7:4]; // [R12]
  // Locks come only from memory that can only lose ones [R14]
  wire rd_ok = (mode == EBR_M_READ) & ~rd_lock & in_range;
  wire wr_ok = (mode == EBR_M_IDLE) & core_halt & ~wr_lock & in_range;
  wire [7:0] status_byte = {5'h00, wr_lock, rd_lock, err}; // [R13] [R7]
  wire [2:0] sel = next_sh[2:0];
  wire [7:0] data_val = rd_ok ? mem[mem_idx] : 8'h00; // [R16]
  wire [7:0] read_val = (sel == R_DEV_CTRL) ? device_control_reg :
                        (sel == R_MEM_CTRL) ? memory_control_reg :
                        (sel == R_ADDRH) ? addr_h :
                        (sel == R_ADDRL) ? addr_l :
                        (sel == R_DATA) ? data_val :
                        (sel == R_STAT) ? status_byte : 8'h00;
  wire frame_end = rise & in_frame & (slot == SLOT_LAST);
  wire [7:0] wdat = next_sh[7:0];
  wire end_wr = frame_end & ~cur_rd;
  wire end_rd_data = frame_end & cur_rd & (cur_reg == R_DATA);
  wire mem_wr = end_wr & (cur_reg == R_DATA) & wr_ok;
  wire soft_rst = end_wr & (cur_reg == R_DEV_CTRL)
                  & (device_control_reg == DEV_CTRL_RST1)
                  & (wdat == DEV_CTRL_RST2); // [R10]
  wire pin_rst = ~rst_s2;

  always_comb begin
    next_mode = mode;
    case (mode)
      EBR_M_IDLE: if (wdat == MEM_CTRL_READ && core_halt) next_mode = EBR_M_READ; // [R4]
      EBR_M_READ: if (wdat == MEM_CTRL_EXIT) next_mode = EBR_M_EXIT; // [R9]
      EBR_M_EXIT: if (wdat == MEM_CTRL_READ) next_mode = EBR_M_IDLE; // [R9]
      default: next_mode = EBR_M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {lk_s1, lk_s2, lk_s3} <= 3'h7;
      {dat_s1, dat_s2, rst_s1, rst_s2} <= 4'hF;
    end else begin
      lk_s1 <= link.lk;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
      dat_s1 <= link.dat;
      dat_s2 <= dat_s1;
      rst_s1 <= link.rst_pin_n;
      rst_s2 <= rst_s1;
    end
  end

  // Frame receiver and read-data driver
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_frame <= 1'b0;
      slot <= 4'h0;
      sh <= 12'h000;
      cur_rd <= 1'b0;
      cur_reg <= 3'h0;
      tx <= 8'h00;
      link.dev_o <= 1'b1;
      link.dev_oe_n <= 1'b1;
    end else if (pin_rst) begin
      in_frame <= 1'b0;
      link.dev_oe_n <= 1'b1;
    end else if (rise) begin
      sh <= next_sh;
      if (!in_frame) begin
        in_frame <= ~dat_s2;
        slot <= 4'h1;
      end else begin
        slot <= slot + 4'h1;
        if (slot == SLOT_SEL_END) begin
          cur_rd <= next_sh[3] != OP_WRITE;
          cur_reg <= sel;
          tx <= read_val; // [R6]
        end
        if (slot == SLOT_LAST) in_frame <= 1'b0;
      end
    end else if (fall) begin
      if (in_frame && cur_rd && slot >= SLOT_DAT) begin
        link.dev_o <= tx[7];
        link.dev_oe_n <= 1'b0;
        tx <= {tx[6:0], 1'b0};
      end else begin
        link.dev_o <= 1'b1;
        link.dev_oe_n <= 1'b1;
      end
    end
  end

  // Register side effects at frame end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      device_control_reg <= 8'h00;
      memory_control_reg <= 8'h00;
      addr_h <= 8'h00;
      addr_l <= 8'h00;
      err <= 1'b0;
      mode <= EBR_M_IDLE;
      core_halt <= 1'b0;
      dev_reset_pulse <= 1'b0;
      read_mode <= 1'b0;
    end else begin
      dev_reset_pulse <= soft_rst; // [R10]
      read_mode <= mode == EBR_M_READ;
      if (pin_rst || soft_rst) begin
        device_control_reg <= 8'h00;
        memory_control_reg <= 8'h00;
        addr_h <= 8'h00;
        addr_l <= 8'h00;
        err <= 1'b0;
        mode <= EBR_M_IDLE;
        core_halt <= 1'b0;
      end else if (end_wr) begin
        case (cur_reg)
          R_DEV_CTRL: begin
            device_control_reg <= wdat;
            core_halt <= wdat[HALT_BIT]; // [R3]
          end
          R_MEM_CTRL: begin
            memory_control_reg <= wdat;
            mode <= next_mode;
          end
          R_ADDRH: addr_h <= wdat;
          R_ADDRL: addr_l <= wdat;
          R_DATA: begin
            err <= ~wr_ok; // [R12]
            if (wr_ok) {addr_h, addr_l} <= addr_pair + 16'h0001;
          end
          default: ;
        endcase
      end else if (end_rd_data) begin
        err <= ~rd_ok; // [R16] [R11]
        if (rd_ok) {addr_h, addr_l} <= addr_pair + 16'h0001; // [R6]
      end
    end
  end

  // One-time cells only clear bits; plain always since the erased image is set at start
  always @(posedge clk) begin
    if (mem_wr) mem[mem_idx] <= mem[mem_idx] & wdat; // [R14]
  end
endmodule

// ### hdl/ebr_host.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module ebr_host (
  // System
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [ebr_pkg::HREG_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Interrupt
  output logic irq,
  // Debug link
  ebr_link_if.host link
);
  import ebr_pkg::*;
  typedef enum logic [2:0] {
    EBR_H_IDLE = 3'b000,
    EBR_H_PIN = 3'b001,
    EBR_H_WAIT = 3'b010,
    EBR_H_LOAD = 3'b011,
    EBR_H_FRAME = 3'b100
  } ebr_hstate_t;

  localparam logic [3:0] PH_HALF = 4'(LK_HALF_CYC);
  localparam logic [3:0] PH_END = 4'(2 * LK_HALF_CYC - 1);
  localparam logic [9:0] PIN_END = 10'(RST_HOLD_CYC - 1);
  localparam logic [9:0] WAIT_END = 10'(RESET_WAIT_CYC - 1);

  ebr_hstate_t state;
  ebr_op_t cur_op;
  logic dat_s1, dat_s2;
  logic [9:0] cnt;
  logic [1:0] step;
  logic [3:0] ph, fslot;
  logic [12:0] fw;
  logic [7:0] rx, last_byte, h_addr_h, h_addr_l, wbuf;
  logic [1:0] irq_stat, irq_mask;
  logic image_done, session_open, frame_rd;
  logic st_rd, st_last;
  logic [2:0] st_reg;
  logic [7:0] st_data;

  // Session step table
  always_comb begin
    st_rd = 1'b0;
    st_reg = R_DEV_CTRL;
    st_data = 8'h00;
    st_last = 1'b1;
    case (cur_op)
      EBR_OP_OPEN: begin
        st_reg = (step == 2'd0) ? R_DEV_CTRL : R_MEM_CTRL;
        st_data = (step == 2'd0) ? DEV_CTRL_HALT : MEM_CTRL_READ; // [R3] [R4]
        st_last = step == 2'd1;
      end
      EBR_OP_ADDR: begin
        st_reg = (step == 2'd0) ? R_ADDRH : R_ADDRL; // [R5] [R8]
        st_data = (step == 2'd0) ? h_addr_h : h_addr_l;
        st_last = step == 2'd1;
      end
      EBR_OP_READ: begin
        st_rd = 1'b1;
        st_reg = (step == 2'd0) ? R_DATA : R_STAT; // [R6] [R7]
        st_last = step == 2'd1;
      end
      EBR_OP_WRITE: begin
        st_reg = R_DATA;
        st_data = wbuf;
      end
      EBR_OP_CLOSE: begin
        st_reg = (step < 2'd2) ? R_MEM_CTRL : R_DEV_CTRL;
        case (step)
          2'd0: st_data = MEM_CTRL_EXIT; // [R9]
          2'd1: st_data = MEM_CTRL_READ; // [R9]
          2'd2: st_data = DEV_CTRL_RST1; // [R10]
          default: st_data = DEV_CTRL_RST2; // [R10]
        endcase
        st_last = step == 2'd3;
      end
      default: ;
    endcase
  end

  // Register port decode
  wire wr_cmd = wr & (addr == H_CMD);
  wire [2:0] cmd_code = wdata[2:0];
  wire idle = state == EBR_H_IDLE;
  wire [15:0] tgt = {h_addr_h, h_addr_l};
  // Guard refuses write commands while the controller address is the lock byte and image_done is clear
  wire lock_early = (cmd_code == EBR_OP_WRITE) & (tgt == SEC_ADDR) & ~image_done; // [R15]
  wire cmd_ok = wr_cmd & idle & ~lock_early & (cmd_code >= EBR_OP_OPEN)
                & (cmd_code <= EBR_OP_CLOSE);
  wire cmd_bad = wr_cmd & (~idle | lock_early);
  wire frame_done = (state == EBR_H_FRAME) & (ph == PH_END) & (fslot == SLOT_STOP);
  wire read_err = frame_done & (cur_op == EBR_OP_READ) & (step == 2'd1)
                  & rx[ST_ERR]; // [R7]
  wire seq_end = frame_done & (st_last | read_err);
  wire [1:0] ev = {cmd_bad | read_err, seq_end};
  wire [1:0] irq_clr = (wr && addr == H_IRQ_STAT) ? wdata[1:0] : 2'b00;
  // A new event wins over a clear in the same cycle
  wire [1:0] next_irq_stat = (irq_stat & ~irq_clr) | ev;
  wire [7:0] status_byte = {6'h00, session_open, ~idle};
  wire [7:0] rsel = (addr == H_ADDRH) ? h_addr_h :
                    (addr == H_ADDRL) ? h_addr_l :
                    (addr == H_WDATA) ? wbuf :
                    (addr == H_RDATA) ? last_byte :
                    (addr == H_STATUS) ? status_byte :
                    (addr == H_IRQ_STAT) ? {6'h00, irq_stat} :
                    (addr == H_IRQ_MASK) ? {6'h00, irq_mask} :
                    (addr == H_IMAGE) ? {7'h00, image_done} : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
    end else begin
      dat_s1 <= link.dat;
      dat_s2 <= dat_s1;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      h_addr_h <= 8'h00;
      h_addr_l <= 8'h00;
      wbuf <= 8'h00;
      image_done <= 1'b0;
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
      irq <= 1'b0;
      rdata <= 8'h00;
    end else begin
      if (wr && addr == H_ADDRH) h_addr_h <= wdata;
      if (wr && addr == H_ADDRL) h_addr_l <= wdata;
      if (wr && addr == H_WDATA) wbuf <= wdata;
      if (wr && addr == H_IMAGE) image_done <= wdata[0];
      if (wr && addr == H_IRQ_MASK) irq_mask <= wdata[1:0];
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
      rdata <= rd ? rsel : 8'h00;
    end
  end

  // Session sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= EBR_H_IDLE;
      cur_op <= EBR_OP_NONE;
      step <= 2'd0;
      cnt <= 10'h000;
      session_open <= 1'b0;
      link.rst_pin_n <= 1'b1;
    end else begin
      case (state)
        EBR_H_IDLE: begin
          step <= 2'd0;
          cnt <= 10'h000;
          if (cmd_ok) begin
            cur_op <= ebr_op_t'(cmd_code);
            state <= (cmd_code == EBR_OP_OPEN) ? EBR_H_PIN : EBR_H_LOAD;
            link.rst_pin_n <= cmd_code != EBR_OP_OPEN; // [R1]
          end
        end
        EBR_H_PIN: begin
          cnt <= cnt + 10'h001;
          if (cnt == PIN_END) begin
            link.rst_pin_n <= 1'b1; // [R1]
            cnt <= 10'h000;
            state <= EBR_H_WAIT;
          end
        end
        EBR_H_WAIT: begin
          cnt <= cnt + 10'h001;
          if (cnt == WAIT_END) state <= EBR_H_LOAD; // [R2]
        end
        EBR_H_LOAD: state <= EBR_H_FRAME;
        EBR_H_FRAME: begin
          if (seq_end) begin
            state <= EBR_H_IDLE;
            if (cur_op == EBR_OP_OPEN) session_open <= 1'b1;
            if (cur_op == EBR_OP_CLOSE) session_open <= 1'b0;
          end else if (frame_done) begin
            step <= step + 2'd1; // [R8]
            state <= EBR_H_LOAD;
          end
        end
        default: state <= EBR_H_IDLE;
      endcase
    end
  end

  // Frame engine: drive on falling link edge, sample on rising
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fw <= 13'h1FFF;
      frame_rd <= 1'b0;
      ph <= 4'h0;
      fslot <= 4'h0;
      rx <= 8'h00;
      last_byte <= 8'h00;
      link.lk <= 1'b1;
      link.host_o <= 1'b1;
      link.host_oe_n <= 1'b1;
    end else if (state == EBR_H_LOAD) begin
      fw <= {1'b0, ~st_rd, st_reg, st_data};
      frame_rd <= st_rd;
      ph <= 4'h0;
      fslot <= 4'h0;
    end else if (state == EBR_H_FRAME) begin
      ph <= (ph == PH_END) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h0) begin
        link.lk <= 1'b0;
        link.host_o <= fw[12];
        fw <= {fw[11:0], 1'b1};
        // Released for read data and for the stop slot
        link.host_oe_n <= ~(fslot < SLOT_DAT || (~frame_rd && fslot <= SLOT_LAST));
      end
      if (ph == PH_HALF) begin
        link.lk <= 1'b1;
        if (frame_rd && fslot >= SLOT_DAT && fslot <= SLOT_LAST) rx <= {rx[6:0], dat_s2};
      end
      if (ph == PH_END) begin
        fslot <= fslot + 4'h1;
        // Byte from a data read kept for software
        if (frame_done && frame_rd && step == 2'd0) last_byte <= rx; // [R6]
      end
    end else begin
      link.lk <= 1'b1;
      link.host_o <= 1'b1;
      link.host_oe_n <= 1'b1;
    end
  end
endmodule

// ### bench/ebr_link_assertions.sv
`timescale 1ns/10ps
module ebr_link_assertions (
  // System
  input wire logic clk,
  input wire logic arst_n,
  // Link wires
  input wire logic lk,
  input wire logic rst_pin_n,
  input wire logic host_oe_n,
  input wire logic dev_oe_n,
  // Device side
  input wire logic core_halt,
  input wire logic dev_reset_pulse,
  input wire logic read_mode
);
  import ebr_pkg::*;
  // Starts saturated so a link used without a pin reset never trips the wait check
  logic [9:0] since_pin;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_pin <= 10'h3FF;
    end else if (!rst_pin_n) begin
      since_pin <= 10'h000;
    end else if (since_pin != 10'h3FF) begin
      since_pin <= since_pin + 10'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_no_contention: assert property (!(!host_oe_n && !dev_oe_n))
    else $error("both ends drive the data line");
  a_lk_low_half: assert property ($fell(lk) |-> !lk [*8] ##1 lk)
    else $error("link clock low phase wrong");
  a_lk_high_half: assert property ($rose(lk) |-> lk [*8])
    else $error("link clock high phase too short");
  a_pin_hold: assert property ($fell(rst_pin_n) |-> !rst_pin_n [*8])
    else $error("pin reset pulse too short");
  a_wait_after_pin: assert property ($fell(lk) |-> since_pin >= RESET_WAIT_CYC)
    else $error("frame too soon after pin reset");
  a_pin_clears_core: assert property (!rst_pin_n |-> ##[0:4] (!core_halt && !read_mode))
    else $error("pin reset left halt or read mode set");
  a_pulse_single: assert property (dev_reset_pulse |=> !dev_reset_pulse)
    else $error("device reset pulse longer than one cycle");
  a_pulse_no_halt: assert property (dev_reset_pulse |-> !core_halt)
    else $error("device reset while core still halted");
  a_read_mode_halted: assert property ($rose(read_mode) |-> core_halt)
    else $error("read mode entered without core halt");
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import ebr_pkg::*;
  logic clk;
  logic arst_n;
  logic [HREG_AW-1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic core_halt;
  logic dev_reset_pulse;
  logic read_mode;
  logic [7:0] st;
  int fail_count = 0;
  int checked = 0;
  int pulses = 0;

  ebr_link_if ebr_link_if_inst ();
  ebr_host ebr_host_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .link(ebr_link_if_inst.host));
  ebr_dev ebr_dev_inst (.clk(clk), .arst_n(arst_n), .link(ebr_link_if_inst.dev),
    .core_halt(core_halt), .dev_reset_pulse(dev_reset_pulse), .read_mode(read_mode));
  ebr_link_assertions ebr_link_assertions_inst (.clk(clk), .arst_n(arst_n),
    .lk(ebr_link_if_inst.lk), .rst_pin_n(ebr_link_if_inst.rst_pin_n),
    .host_oe_n(ebr_link_if_inst.host_oe_n), .dev_oe_n(ebr_link_if_inst.dev_oe_n),
    .core_halt(core_halt), .dev_reset_pulse(dev_reset_pulse), .read_mode(read_mode));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dev_reset_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  task finish_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data live only in the cycle after the strobe, so take it mid-cycle
  task rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task finish_cmd(output logic [7:0] s);
    logic [7:0] b;
    int n;
    n = 0;
    b = 8'h01;
    while (b[0] !== 1'b0 && n < 3000) begin
      rd_reg(H_STATUS, b);
      n++;
    end
    cmp({15'h0000, n < 3000}, 16'h0001);
    rd_reg(H_IRQ_STAT, s);
    wr_reg(H_IRQ_STAT, 8'h03);
  endtask

  task do_cmd(input ebr_op_t op, output logic [7:0] s);
    wr_reg(H_CMD, {5'h00, op});
    finish_cmd(s);
  endtask

  task set_addr(input logic [15:0] a);
    wr_reg(H_ADDRH, a[15:8]);
    wr_reg(H_ADDRL, a[7:0]);
    do_cmd(EBR_OP_ADDR, st);
  endtask

  task read_one(input logic [7:0] exp_d, input logic exp_err);
    logic [7:0] d;
    do_cmd(EBR_OP_READ, st);
    cmp({15'h0000, st[IRQ_ERR]}, {15'h0000, exp_err});
    rd_reg(H_RDATA, d);
    cmp({8'h00, d}, {8'h00, exp_d});
  endtask

  task t_idle;
    cmp({13'h0000, ebr_link_if_inst.lk, ebr_link_if_inst.rst_pin_n, ebr_link_if_inst.dat},
      16'h0007);
    rd_reg(4'hF, st);
    cmp({8'h00, st}, 16'h0000);
    wr_reg(H_IRQ_MASK, 8'h03);
    rd_reg(H_IRQ_MASK, st);
    cmp({8'h00, st}, 16'h0003);
  endtask

  task t_early_read;
    set_addr(16'h0000);
    read_one(8'h00, 1'b1);
  endtask

  task t_open;
    logic [13:0] bits;
    int n;
    // Strobe driven here so the first cycle of the pin pulse is counted too
    addr <= H_CMD;
    wdata <= {5'h00, EBR_OP_OPEN};
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    n = 0;
    @(negedge clk);
    while (ebr_link_if_inst.rst_pin_n !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (ebr_link_if_inst.rst_pin_n === 1'b0 && n < 100) begin
      n++;
      @(negedge clk);
    end
    cmp(n[15:0], RST_HOLD_CYC[15:0]);
    n = 0;
    while (ebr_link_if_inst.lk === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
    cmp({15'h0000, n >= RESET_WAIT_CYC}, 16'h0001);
    bits = 14'h0000;
    for (int i = 0; i < 14; i++) begin
      @(posedge ebr_link_if_inst.lk);
      bits = {bits[12:0], ebr_link_if_inst.dat};
    end
    cmp({2'b00, bits}, {2'b00, 1'b0, OP_WRITE, R_DEV_CTRL, DEV_CTRL_HALT, 1'b1});
    finish_cmd(st);
    cmp({8'h00, st}, 16'h0001);
    cmp({14'h0000, core_halt, read_mode}, 16'h0003);
  endtask

  task t_read_seq;
    set_addr(16'h0FFF);
    read_one(ERASED, 1'b0);
    // Past the top of memory: an error here shows the address moved on
    read_one(8'h00, 1'b1);
    read_one(8'h00, 1'b1);
    set_addr(16'h0000);
    read_one(ERASED, 1'b0);
    read_one(ERASED, 1'b0);
  endtask

  task t_write_refused;
    wr_reg(H_IMAGE, 8'h00);
    set_addr(SEC_ADDR);
    wr_reg(H_WDATA, 8'h00);
    do_cmd(EBR_OP_WRITE, st);
    cmp({15'h0000, st[IRQ_ERR]}, 16'h0001);
    set_addr(SEC_ADDR);
    read_one(ERASED, 1'b0);
    set_addr(16'h0000);
    do_cmd(EBR_OP_WRITE, st);
    set_addr(16'h0000);
    read_one(ERASED, 1'b0);
  endtask

  // Two command writes back to back: the second lands while busy
  task t_busy;
    addr <= H_CMD;
    wdata <= {5'h00, EBR_OP_ADDR};
    wr <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    finish_cmd(st);
    cmp({8'h00, st}, 16'h0003);
  endtask

  task t_irq;
    wr_reg(H_IRQ_MASK, 8'h00);
    wr_reg(H_CMD, {5'h00, EBR_OP_ADDR});
    repeat (600) @(posedge clk);
    @(negedge clk);
    cmp({15'h0000, irq}, 16'h0000);
    wr_reg(H_IRQ_MASK, 8'h01);
    @(negedge clk);
    cmp({15'h0000, irq}, 16'h0001);
    wr_reg(H_IRQ_STAT, 8'h01);
    @(negedge clk);
    cmp({15'h0000, irq}, 16'h0000);
    wr_reg(H_IRQ_MASK, 8'h03);
  endtask

  task t_close;
    int p0;
    p0 = pulses;
    do_cmd(EBR_OP_CLOSE, st);
    cmp(16'(pulses - p0), 16'h0001);
    cmp({14'h0000, core_halt, read_mode}, 16'h0000);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("BAD %0t: timeout", $time);
    finish_test();
  end

  initial begin
    addr = '0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_idle();
    t_early_read();
    t_open();
    t_read_seq();
    t_write_refused();
    t_busy();
    t_irq();
    t_close();
    finish_test();
  end
endmodule
